/* File: sim/reset_cause_recorder_tb.sv */
// self-checking bench for the reset cause recorder
`timescale 1ns/1ps
`default_nettype none
module reset_cause_recorder_tb
  import rcr_pkg::*;
;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, strb;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp, brownout_mode;
  rcr_evt_type evt;
  logic asleep, stack_fault_reset_enable, global_irq_enable, brownout_ready;
  logic pc_load, irq_redirect, brownout_enable;
  logic [PC_W-1:0] cur_pc, pc_target;
  int errors, num_checks, cyc, cause, status, swen, be;
  rcr_top rcr_top_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt, .asleep,
    .stack_fault_reset_enable, .global_irq_enable, .brownout_mode, .brownout_ready, .cur_pc, .pc_load,
    .pc_target, .irq_redirect, .brownout_enable);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [3:0] a, input int exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    if (er === RESP_OKAY) chk("rdata", s_axi_rdata, exp);
  endtask : rd
  task automatic regs();
    rd(OFS_CAUSE, cause, RESP_OKAY);
    rd(OFS_STATUS, status, RESP_OKAY);
  endtask : regs
  // one-cycle event pulse, then vector outputs and both flag registers
  task automatic ev(input logic [6:0] e, input bit wake, input bit ld, input bit irq);
    logic [PC_W-1:0] pc;
    seed = xs(seed);
    pc = seed[PC_W-1:0];
    @(posedge clk);
    cur_pc <= pc;
    brownout_ready <= seed[20];
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
    chk("pc_load", {31'h0, pc_load}, {31'h0, ld});
    if (ld) chk("pc_target", {17'h0, pc_target}, wake ? {17'h0, pc + 15'h0001} : {17'h0, RESET_VEC});
    chk("irq_redirect", {31'h0, irq_redirect}, {31'h0, irq});
    regs();
  endtask : ev
  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    seed = 32'hE8E8F6D9;
    strb = 4'hF;
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, evt, cur_pc} = '0;
    {asleep, stack_fault_reset_enable, global_irq_enable, brownout_ready, brownout_mode} = 6'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cause = 8'h0C;
    status = 8'h18;
    regs();
    rd(OFS_BROWNOUT, 8'h80, RESP_OKAY);
    wr(OFS_CAUSE, 8'hFF, RESP_OKAY);
    cause = 8'hCF;
    regs();
    wr(OFS_STATUS, 8'h00, RESP_OKAY);
    regs();
    rd(4'hC, 0, RESP_SLVERR);
    wr(4'hC, 8'h00, RESP_SLVERR);
    cause = cause & 8'hF7;
    ev(7'h20, 0, 1, 0);
    cause = cause & 8'hFB;
    ev(7'h04, 0, 1, 0);
    wr(OFS_CAUSE, 8'h0F, RESP_OKAY);
    cause = 8'h0F;
    ev(7'h02, 0, 0, 0);
    ev(7'h01, 0, 0, 0);
    stack_fault_reset_enable <= 1'b1;
    cause = cause | 8'h80;
    ev(7'h02, 0, 1, 0);
    cause = cause | 8'h40;
    ev(7'h01, 0, 1, 0);
    status = status & 8'h08;
    ev(7'h10, 0, 1, 0);
    asleep <= 1'b1;
    cause = cause & 8'hF7;
    status = 8'h10;
    ev(7'h20, 0, 1, 0);
    status = 8'h00;
    ev(7'h10, 1, 1, 0);
    global_irq_enable <= 1'b1;
    status = 8'h10;
    ev(7'h08, 1, 1, 1);
    global_irq_enable <= 1'b0;
    ev(7'h08, 1, 1, 0);
    cause = (cause & 8'h02) | 8'h0C;
    status = 8'h18;
    ev(7'h44, 0, 1, 0);
    seed = xs(seed);
    wr(OFS_CAUSE, seed[7:0], RESP_OKAY);
    cause = seed[7:0] & 8'hCF;
    regs();
    // low byte lane off: the write must leave the flags alone
    strb = 4'hE;
    wr(OFS_CAUSE, 8'h00, RESP_OKAY);
    strb = 4'hF;
    regs();
    // stack underflow lands on the very edge that performs a clearing write
    fork
      wr(OFS_CAUSE, 8'h00, RESP_OKAY);
      begin
        repeat (2) @(posedge clk);
        evt <= 7'h01;
        @(posedge clk);
        evt <= '0;
      end
    join
    cause = 8'h40;
    regs();
    // every enable mode, awake and asleep, with a random software enable
    for (int m = 0; m < 8; m++)
    begin
      seed = xs(seed);
      wr(OFS_BROWNOUT, seed[7:0], RESP_OKAY);
      swen = seed[7];
      brownout_mode <= m[1:0];
      asleep <= m[2];
      repeat (2) @(posedge clk);
      be = (m % 4 == 3) || (m % 4 == 2 && m < 4) || (m % 4 == 1 && swen == 1);
      chk("bor_en", {31'h0, brownout_enable}, be);
      rd(OFS_BROWNOUT, swen * 128 + brownout_ready, RESP_OKAY);
    end
    // second power-on in mid-run must restore every flag
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("pc_load", {31'h0, pc_load}, 32'h1);
    chk("bor_en", {31'h0, brownout_enable}, 32'h0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cause = 8'h0C;
    status = 8'h18;
    regs();
    rd(OFS_BROWNOUT, 8'h80 + brownout_ready, RESP_OKAY);
    end_sim();
  end
endmodule : reset_cause_recorder_tb
`default_nettype wire

/* File: src/rcr_pkg.sv */
// package: register map, flag positions, reset values and event carrier
package rcr_pkg;
  localparam logic [3:0] OFS_BROWNOUT = 4'h0;
  localparam logic [3:0] OFS_CAUSE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam int BIT_STACK_HIGH = 7;
  localparam int BIT_STACK_LOW = 6;
  localparam int BIT_EXT_PIN = 3;
  localparam int BIT_SOFT_RST = 2;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_WDT_EXP = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_SW_BOR_EN = 7;
  localparam int BIT_BOR_READY = 0;
  localparam logic [7:0] CAUSE_MASK = 8'hCF;
  localparam logic [7:0] STATUS_MASK = 8'h18;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h0C;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic SW_BOR_EN_POR_VAL = 1'b1;
  localparam int PC_W = 15;
  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 15'h0004;
  localparam logic [1:0] BOR_MODE_SW = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic bor;
    logic pin;
    logic wdt;
    logic irq_wake;
    logic reset_instr;
    logic stack_high;
    logic stack_low;
  } rcr_evt_type;
endpackage : rcr_pkg

/* File: src/rcr_top.sv */
// reset cause recorder with its axi4-lite register slave
// Operation
// - every reset or wake updates flags, vector
// - power-on: power flag 0, stacks 0, pin/soft 1
// - brown-out: clear flag, stacks; set pin/soft
// - pin reset clears pin flag; firmware resets it
// - reset instruction clears soft flag, restarts
// - enabled stack overflow sets high flag
// - enabled stack underflow sets low flag
// - cause bits 5 and 4 read zero
// - power-on and brown-out set expiry, sleep
// - pin reset asleep: expiry 1, sleep 0
// - pin reset awake leaves status alone
// - watchdog wake: clear both, continue next
// - interrupt wake: next first, then vector
// - unimplemented status bits read zero
// - watchdog reset awake clears expiry, restarts
// - software enable acts only in software mode
`timescale 1ns/1ps
`default_nettype none
module rcr_top
  import rcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rcr_evt_type evt,
  input wire logic asleep,
  input wire logic stack_fault_reset_enable,
  input wire logic global_irq_enable,
  input wire logic [1:0] brownout_mode,
  input wire logic brownout_ready,
  input wire logic [PC_W-1:0] cur_pc,
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic irq_redirect,
  output logic brownout_enable
);

  // ********************************
  // bus slave
  // ********************************
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [7:0] cause;
  logic [7:0] status;
  logic sw_bor_en;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == OFS_BROWNOUT) || (a == OFS_CAUSE) || (a == OFS_STATUS);
  endfunction : mapped

  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_cause = wr_fire && w_lane0 && (aw_addr == OFS_CAUSE);
  wire wr_bor = wr_fire && w_lane0 && (aw_addr == OFS_BROWNOUT);
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  // status is read only: expiry and sleep flags belong to hardware
  wire [7:0] bor_view = {sw_bor_en, 6'h00, brownout_ready};
  wire [7:0] rd_byte = (s_axi_araddr == OFS_BROWNOUT) ? bor_view :
                       (s_axi_araddr == OFS_CAUSE) ? (cause & CAUSE_MASK) :
                       (s_axi_araddr == OFS_STATUS) ? (status & STATUS_MASK) : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ********************************
  // cause and status flags
  // ********************************
  // stack faults only reset the core when the configuration allows it
  wire stk_hi = evt.stack_high && stack_fault_reset_enable;
  wire stk_lo = evt.stack_low && stack_fault_reset_enable;
  wire pin_sleep = evt.pin && asleep;
  wire wdt_sleep = evt.wdt && asleep;
  wire wdt_awake = evt.wdt && !asleep;
  wire true_reset = evt.bor || evt.pin || wdt_awake || evt.reset_instr || stk_hi || stk_lo;
  wire wake = wdt_sleep || evt.irq_wake;
  logic [7:0] next_cause;
  logic [7:0] next_status;

  always_comb
  begin
    // firmware first, then hardware events override bit by bit
    next_cause = wr_cause ? (w_byte & CAUSE_MASK) : cause;
    next_status = status;
    if (stk_hi)
      next_cause[BIT_STACK_HIGH] = 1'b1;
    if (stk_lo)
      next_cause[BIT_STACK_LOW] = 1'b1;
    if (evt.reset_instr)
      next_cause[BIT_SOFT_RST] = 1'b0;
    if (evt.pin)
      next_cause[BIT_EXT_PIN] = 1'b0;
    if (pin_sleep)
    begin
      next_status[BIT_WDT_EXP] = 1'b1;
      next_status[BIT_SLEEP] = 1'b0;
    end
    if (wdt_awake)
      next_status[BIT_WDT_EXP] = 1'b0;
    if (wdt_sleep)
    begin
      next_status[BIT_WDT_EXP] = 1'b0;
      next_status[BIT_SLEEP] = 1'b0;
    end
    if (evt.irq_wake)
    begin
      next_status[BIT_WDT_EXP] = 1'b1;
      next_status[BIT_SLEEP] = 1'b0;
    end
    if (evt.bor)
    begin
      next_cause[BIT_BROWNOUT] = 1'b0;
      next_cause[BIT_STACK_HIGH] = 1'b0;
      next_cause[BIT_STACK_LOW] = 1'b0;
      next_cause[BIT_EXT_PIN] = 1'b1;
      next_cause[BIT_SOFT_RST] = 1'b1;
      next_status[BIT_WDT_EXP] = 1'b1;
      next_status[BIT_SLEEP] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cause <= CAUSE_POR_VAL;
      status <= STATUS_POR_VAL;
      sw_bor_en <= SW_BOR_EN_POR_VAL;
    end
    else
    begin
      cause <= next_cause & CAUSE_MASK;
      status <= next_status & STATUS_MASK;
      if (wr_bor)
        sw_bor_en <= w_byte[BIT_SW_BOR_EN];
    end
  end

  // ********************************
  // program counter redirect and brown-out enable
  // ********************************
  wire [PC_W-1:0] pc_next = cur_pc + 15'h0001;
  wire bor_on = (brownout_mode == BOR_MODE_SW) ? sw_bor_en :
                (brownout_mode[1] && !(brownout_mode == 2'h2 && asleep));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_load <= 1'b1;
      pc_target <= RESET_VEC;
      irq_redirect <= 1'b0;
      brownout_enable <= 1'b0;
    end
    else
    begin
      pc_load <= true_reset || wake;
      pc_target <= true_reset ? RESET_VEC : pc_next;
      irq_redirect <= !true_reset && evt.irq_wake && global_irq_enable;
      brownout_enable <= bor_on;
    end
  end

  // ********************************
  // assertions
  // ********************************
  property p_pin_clear;
    @(posedge clk) disable iff (rst) (evt.pin && !evt.bor) |=> !cause[BIT_EXT_PIN];
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin reset left flag set");

  property p_bor_flags;
    @(posedge clk) disable iff (rst) evt.bor |=> (cause[7:2] == 6'h03) && !cause[BIT_BROWNOUT] && status == 8'h18;
  endproperty
  a_bor_flags: assert property (p_bor_flags) else $error("brown-out flags wrong");

  property p_soft_vec;
    @(posedge clk) disable iff (rst) evt.reset_instr |=> pc_load && pc_target == RESET_VEC;
  endproperty
  a_soft_vec: assert property (p_soft_vec) else $error("reset instruction vector wrong");

  property p_stack_gate;
    @(posedge clk) disable iff (rst)
      (evt.stack_high && !stack_fault_reset_enable && !wr_cause && !evt.bor && !evt.pin && !evt.reset_instr)
      |=> $stable(cause);
  endproperty
  a_stack_gate: assert property (p_stack_gate) else $error("disabled stack fault changed flags");

  property p_unimpl;
    @(posedge clk) disable iff (rst) cause[5:4] == 2'h0 && (status & ~STATUS_MASK) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_wdt_wake;
    @(posedge clk) disable iff (rst) (evt.wdt && asleep && !true_reset && !evt.irq_wake)
      |=> status[4:3] == 2'h0 && pc_target == $past(cur_pc) + 15'h0001 && pc_load;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_irq;
    @(posedge clk) disable iff (rst) (evt.irq_wake && global_irq_enable && !true_reset)
      |=> irq_redirect ##1 (!irq_redirect || $past(evt.irq_wake));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt redirect missing");

  property p_hw_wins;
    @(posedge clk) disable iff (rst) (wr_cause && stk_lo && !evt.bor) |=> cause[BIT_STACK_LOW];
  endproperty
  a_hw_wins: assert property (p_hw_wins) else $error("firmware write beat hardware");

  property p_bresp;
    @(posedge clk) disable iff (rst) (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response dropped");

  c_bor: cover property (@(posedge clk) disable iff (rst) evt.bor ##1 pc_load);
  c_wdt_wake: cover property (@(posedge clk) disable iff (rst) wdt_sleep ##1 pc_load);
  c_irq: cover property (@(posedge clk) disable iff (rst) irq_redirect);
  c_write: cover property (@(posedge clk) disable iff (rst) wr_cause ##1 s_axi_bvalid);

endmodule : rcr_top
`default_nettype wire
